// [core/mfd_defines.vh]
`ifndef MFD_DEFINES_VH
`define MFD_DEFINES_VH

// Data widths
`define MFD_IN_W          12
`define MFD_FULL_W        18
`define MFD_RED_W         14
`define MFD_EXT_W         6
`define MFD_DROP_W        4

// Rate factors and input buffer depth
`define MFD_DEC_M         4
`define MFD_INT_P         4
`define MFD_START_DEPTH   8
`define MFD_DEC_M_CNT     4'h4
`define MFD_START_CNT     4'h8

// APB register byte offsets
`define MFD_ADDR_CTRL     8'h00
`define MFD_ADDR_ROUND    8'h04
`define MFD_ADDR_CYCLES   8'h08
`define MFD_ADDR_STATUS   8'h0c
`define MFD_ADDR_OUTCNT   8'h10

// Control register fields
`define MFD_CTRL_INT      0
`define MFD_CTRL_CE       1
`define MFD_CTRL_DA       2
`define MFD_CTRL_W        3

// Reset values
`define MFD_CTRL_RST      3'h0
`define MFD_ROUND_RST     4'h0
`define MFD_CYCLES_RST    8'h04

// Output styles
`define MFD_RND_FULL      4'h0
`define MFD_RND_TRUNC     4'h1
`define MFD_RND_DOWN      4'h2
`define MFD_RND_UP        4'h3
`define MFD_RND_SZERO     4'h4
`define MFD_RND_ASZERO    4'h5
`define MFD_RND_SINF      4'h6
`define MFD_RND_ASINF     4'h7
`define MFD_RND_CEVEN     4'h8
`define MFD_RND_CODD      4'h9

`endif

// [core/mfd_top.v]
`timescale 1ns/10ps
`default_nettype none

`include "mfd_defines.vh"

module mfd_top (
  // Clock and reset
  input  wire                     pclk,
  input  wire                     presetn,
  // APB slave
  input  wire                     psel,
  input  wire                     penable,
  input  wire                     pwrite,
  input  wire [7:0]               paddr,
  input  wire [31:0]              pwdata,
  output wire [31:0]              prdata,
  output wire                     pready,
  output wire                     pslverr,
  // Sample input
  input  wire [`MFD_IN_W-1:0]     sample_in,
  input  wire                     new_sample_strobe,
  input  wire                     ce,
  output wire                     ready_for_data,
  // Sample output
  output wire [`MFD_FULL_W-1:0]   sample_out,
  output wire                     output_valid,
  input  wire                     out_ready
);

  // Sign extension to the internal result width
  function [`MFD_FULL_W-1:0] mfd_sext;
    input [`MFD_IN_W-1:0] x;
    begin
      mfd_sext = {{`MFD_EXT_W{x[`MFD_IN_W-1]}}, x};
    end
  endfunction

  // Output width reduction; reduced results are sign extended
  function [`MFD_FULL_W-1:0] mfd_round;
    input [3:0]             mode;
    input [`MFD_FULL_W-1:0] x;
    reg   [`MFD_RED_W-1:0]  kept;
    reg   [`MFD_RED_W-1:0]  r;
    reg                     dmsb;
    reg                     drest;
    reg                     s;
    reg                     inc;
    begin
      kept  = x[`MFD_FULL_W-1:`MFD_DROP_W];
      dmsb  = x[`MFD_DROP_W-1];
      drest = |x[`MFD_DROP_W-2:0];
      s     = x[`MFD_FULL_W-1];
      case (mode)
        `MFD_RND_UP:     inc = dmsb;
        `MFD_RND_SZERO:  inc = dmsb & (s | drest);
        `MFD_RND_ASZERO: inc = dmsb & s;
        `MFD_RND_SINF:   inc = dmsb & (~s | drest);
        `MFD_RND_ASINF:  inc = dmsb & ~s;
        `MFD_RND_CEVEN:  inc = dmsb & (drest | kept[0]);
        `MFD_RND_CODD:   inc = dmsb & (drest | ~kept[0]);
        default:         inc = 1'b0;
      endcase
      r = kept + {{(`MFD_RED_W-1){1'b0}}, inc};
      if (mode == `MFD_RND_FULL)
        mfd_round = x;
      else
        mfd_round = {{`MFD_DROP_W{r[`MFD_RED_W-1]}}, r};
    end
  endfunction

  // Configuration and status registers
  reg  [`MFD_CTRL_W-1:0]   ctrl_reg;
  reg  [3:0]               round_reg;
  reg  [7:0]               cycles_reg;
  reg  [15:0]              out_cnt_reg;
  reg  [31:0]              prdata_reg;
  reg                      perr_reg;

  // Decimator state
  reg  [`MFD_IN_W-1:0]     db_reg [0:`MFD_START_DEPTH-1];
  reg  [3:0]               dcnt_reg;
  reg                      start_reg;
  reg  [`MFD_FULL_W-1:0]   acc_reg;
  reg                      res_valid_reg;

  // Shared sub-filter cycle counter
  reg  [7:0]               calc_cnt_reg;

  // Interpolator state
  reg  [`MFD_IN_W-1:0]     ihold_reg;
  reg  [`MFD_FULL_W-1:0]   bank_reg [0:`MFD_INT_P-1];
  reg                      bank_valid_reg;
  reg  [1:0]               seq_reg;

  // Two-entry output buffer
  reg  [`MFD_FULL_W-1:0]   ob_reg [0:1];
  reg  [1:0]               ob_cnt_reg;

  wire                     mode_int;
  wire                     ctl_ce;
  wire                     arch_da;
  wire                     adv;
  wire [7:0]               lcyc;
  wire [3:0]               eff_round;
  wire                     take;
  wire                     dec_take;
  wire                     int_take;
  wire                     dec_start;
  wire [3:0]               dec_wi;
  wire [`MFD_FULL_W-1:0]   dec_sum;
  wire                     bank_free;
  wire                     calc_step;
  wire                     calc_done;
  wire                     int_latch;
  wire                     push_valid;
  wire [`MFD_FULL_W-1:0]   push_data;
  wire                     ob_in_ready;
  wire                     ob_push;
  wire                     ob_pop;
  wire                     apb_wr;
  wire                     apb_setup;
  reg  [31:0]              rd_mux;
  reg                      rd_err;

  assign mode_int  = ctrl_reg[`MFD_CTRL_INT];
  assign ctl_ce    = ctrl_reg[`MFD_CTRL_CE];
  assign arch_da   = ctrl_reg[`MFD_CTRL_DA];
  // Zero would stall the counter forever, so it means one
  assign lcyc      = (cycles_reg == 8'h00) ? 8'h01 : cycles_reg;

  assign adv       = ctl_ce ? ce : 1'b1;

  assign eff_round = arch_da ? `MFD_RND_FULL : round_reg;

  assign take      = ready_for_data & (ctl_ce ? ce : new_sample_strobe);
  assign dec_take  = take & ~mode_int;
  assign int_take  = take & mode_int;

  // Eight from rest, counting a block in the engine
  assign ready_for_data = mode_int ?
                          ((calc_cnt_reg == 8'h00) |
                           (calc_cnt_reg == 8'h01 & calc_step)) :
                          (dcnt_reg < ((start_reg & ~res_valid_reg &
                                        (calc_cnt_reg == 8'h00)) ?
                                       `MFD_START_CNT : `MFD_DEC_M_CNT));

  // Decimator consumes a block of four once the engine is free
  assign dec_start = ~mode_int & adv & (calc_cnt_reg == 8'h00) &
                     ~res_valid_reg & (dcnt_reg >= `MFD_DEC_M_CNT);
  assign dec_wi    = dec_start ? dcnt_reg - `MFD_DEC_M_CNT : dcnt_reg;
  assign dec_sum   = mfd_sext(db_reg[0]) + mfd_sext(db_reg[1]) +
                     mfd_sext(db_reg[2]) + mfd_sext(db_reg[3]);

  // Last phase leaving the bank frees it for the next block
  assign bank_free = ~bank_valid_reg |
                     (ob_push & (seq_reg == 2'd3));
  assign calc_step = adv & (calc_cnt_reg != 8'h00) &
                     ~(mode_int & (calc_cnt_reg == 8'h01) & ~bank_free);
  assign calc_done = calc_step & (calc_cnt_reg == 8'h01);
  assign int_latch = mode_int & calc_done;

  assign push_valid = mode_int ? bank_valid_reg : res_valid_reg;
  assign push_data  = mfd_round(eff_round,
                                mode_int ? bank_reg[seq_reg] : acc_reg);

  // Refusing on full keeps the buffer honest; upstream stalls instead
  assign ob_in_ready = (ob_cnt_reg != 2'd2);
  assign ob_push     = push_valid & ob_in_ready & adv;
  assign ob_pop      = (ob_cnt_reg != 2'd0) & out_ready & adv;

  assign output_valid = ob_pop;
  assign sample_out   = ob_reg[0];

  // APB: one wait-free access phase; read data captured at setup
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite;
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & perr_reg;
  assign prdata    = prdata_reg;

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      `MFD_ADDR_CTRL:   rd_mux = {29'h0, ctrl_reg};
      `MFD_ADDR_ROUND:  rd_mux = {28'h0, round_reg};
      `MFD_ADDR_CYCLES: rd_mux = {24'h0, cycles_reg};
      `MFD_ADDR_STATUS: rd_mux = {22'h0, ob_cnt_reg,
                                  calc_cnt_reg != 8'h00,
                                  push_valid, ready_for_data,
                                  start_reg, dcnt_reg};
      `MFD_ADDR_OUTCNT: rd_mux = {16'h0, out_cnt_reg};
      default:          rd_err = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= `MFD_CTRL_RST;
      round_reg   <= `MFD_ROUND_RST;
      cycles_reg  <= `MFD_CYCLES_RST;
      prdata_reg  <= 32'h0000_0000;
      perr_reg    <= 1'b0;
      out_cnt_reg <= 16'h0000;
    end else begin
      if (apb_setup) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
        perr_reg   <= rd_err;
      end
      if (apb_wr) begin
        case (paddr)
          `MFD_ADDR_CTRL:   ctrl_reg   <= pwdata[`MFD_CTRL_W-1:0];
          `MFD_ADDR_ROUND:  round_reg  <= pwdata[3:0];
          `MFD_ADDR_CYCLES: cycles_reg <= pwdata[7:0];
          default:          ctrl_reg   <= ctrl_reg;
        endcase
      end
      if (ob_pop)
        out_cnt_reg <= out_cnt_reg + 16'h0001;
    end
  end

  // Decimator input buffer: shift down by a block, then write
  genvar i;
  generate
    for (i = 0; i < `MFD_START_DEPTH; i = i + 1) begin : g_dbuf
      wire [`MFD_IN_W-1:0] shifted;
      if (i < `MFD_START_DEPTH - `MFD_DEC_M) begin : g_sh
        assign shifted = dec_start ? db_reg[i + `MFD_DEC_M] : db_reg[i];
      end else begin : g_hold
        assign shifted = db_reg[i];
      end
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          db_reg[i] <= {`MFD_IN_W{1'b0}};
        else if (dec_take && dec_wi == i)
          db_reg[i] <= sample_in;
        else
          db_reg[i] <= shifted;
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcnt_reg      <= 4'h0;
      start_reg     <= 1'b1;
      acc_reg       <= {`MFD_FULL_W{1'b0}};
      res_valid_reg <= 1'b0;
      calc_cnt_reg  <= 8'h00;
      ihold_reg     <= {`MFD_IN_W{1'b0}};
    end else begin
      dcnt_reg <= dec_wi + {3'h0, dec_take};
      if (dec_start)
        acc_reg <= dec_sum;
      if (dec_start || int_take)
        calc_cnt_reg <= lcyc;
      else if (calc_step)
        calc_cnt_reg <= calc_cnt_reg - 8'h01;
      if (int_take)
        ihold_reg <= sample_in;
      if (~mode_int && calc_done)
        res_valid_reg <= 1'b1;
      else if (~mode_int && ob_push)
        res_valid_reg <= 1'b0;
      if (~mode_int && ob_push)
        start_reg <= 1'b0;
    end
  end

  genvar k;
  generate
    for (k = 0; k < `MFD_INT_P; k = k + 1) begin : g_phase
      localparam [`MFD_FULL_W-1:0] WEIGHT = k + 1;
      wire [`MFD_FULL_W-1:0] phase_val = mfd_sext(ihold_reg) * WEIGHT;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          bank_reg[k] <= {`MFD_FULL_W{1'b0}};
        else if (int_latch)
          bank_reg[k] <= phase_val;
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_valid_reg <= 1'b0;
      seq_reg        <= 2'd0;
    end else begin
      if (mode_int && ob_push)
        seq_reg <= seq_reg + 2'd1;
      if (int_latch)
        bank_valid_reg <= 1'b1;
      else if (mode_int && ob_push && seq_reg == 2'd3)
        bank_valid_reg <= 1'b0;
    end
  end

  // Output buffer; head register feeds the sink directly
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ob_reg[0]  <= {`MFD_FULL_W{1'b0}};
      ob_reg[1]  <= {`MFD_FULL_W{1'b0}};
      ob_cnt_reg <= 2'd0;
    end else begin
      case ({ob_push, ob_pop})
        2'b11: begin
          if (ob_cnt_reg == 2'd1) begin
            ob_reg[0] <= push_data;
          end else begin
            ob_reg[0] <= ob_reg[1];
            ob_reg[1] <= push_data;
          end
        end
        2'b01: begin
          ob_reg[0]  <= ob_reg[1];
          ob_cnt_reg <= ob_cnt_reg - 2'd1;
        end
        2'b10: begin
          if (ob_cnt_reg == 2'd0)
            ob_reg[0] <= push_data;
          else
            ob_reg[1] <= push_data;
          ob_cnt_reg <= ob_cnt_reg + 2'd1;
        end
        default: ob_cnt_reg <= ob_cnt_reg;
      endcase
    end
  end

endmodule

`default_nettype wire

// [tb/mfd_top_sva.sv]
`timescale 1ns/10ps
`default_nettype none
`include "mfd_defines.vh"
module mfd_top_sva (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // Stream
  input wire logic        new_sample_strobe,
  input wire logic        ce,
  input wire logic        ready_for_data,
  input wire logic        output_valid,
  input wire logic        out_ready
);
  logic [2:0] ctrl_reg;
  logic [3:0] take_reg;
  logic       seen_reg;
  wire        ce_mode = ctrl_reg[1];
  wire        int_mode = ctrl_reg[0];
  wire        taken = ready_for_data && (ce_mode ? ce : new_sample_strobe);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Mode shadowed from bus writes, ports only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 3'h0;
      take_reg <= 4'h0;
      seen_reg <= 1'b0;
    end else begin
      if (psel && penable && pwrite && paddr == `MFD_ADDR_CTRL)
        ctrl_reg <= pwdata[2:0];
      if (taken && take_reg != 4'hf)
        take_reg <= take_reg + 4'h1;
      if (output_valid)
        seen_reg <= 1'b1;
    end
  end
  sequence s_first;
    int_mode && $rose(output_valid) && out_ready;
  endsequence
  sequence s_four;
    output_valid [*4];
  endsequence
  property p_start_fill;
    !seen_reg && !int_mode && take_reg < 4'h8 |-> ready_for_data;
  endproperty
  a_start_fill: assert property (p_start_fill)
    else $error("ready dropped before eight samples");
  property p_start_stop;
    !seen_reg && !int_mode && taken && take_reg == 4'h7 |=> !ready_for_data;
  endproperty
  a_start_stop: assert property (p_start_stop)
    else $error("ready held after eight start-up samples");
  property p_ready_hold;
    ready_for_data && !taken |=> ready_for_data;
  endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("ready dropped without a take");
  property p_valid_sink;
    output_valid |-> out_ready;
  endproperty
  a_valid_sink: assert property (p_valid_sink)
    else $error("valid while sink stalled");
  property p_ce_gate;
    ce_mode && !ce |-> !output_valid;
  endproperty
  a_ce_gate: assert property (p_ce_gate)
    else $error("output without clock enable");
  property p_ce_hold;
    ce_mode && !ce |=> $stable(ready_for_data);
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("state moved without clock enable");
  property p_phase_run;
    s_first |-> s_four;
  endproperty
  a_phase_run: assert property (p_phase_run)
    else $error("phase block not sequenced");
  property p_prdata_hold;
    psel && penable |=> $stable(prdata);
  endproperty
  a_prdata_hold: assert property (p_prdata_hold)
    else $error("read data changed after access");
  property p_pready;
    psel && penable |-> pready;
  endproperty
  a_pready: assert property (p_pready)
    else $error("access not answered");
endmodule
bind mfd_top mfd_top_sva chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .new_sample_strobe(new_sample_strobe), .ce(ce),
  .ready_for_data(ready_for_data), .output_valid(output_valid),
  .out_ready(out_ready));
`default_nettype wire

// [tb/mfd_sink.sv]
`timescale 1ns/10ps
`default_nettype none
module mfd_sink (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Result stream
  input  wire logic [17:0] sample_out,
  input  wire logic        output_valid,
  output logic             out_ready,
  // Bench control
  input  wire logic        stall
);
  logic [17:0] got [0:127];
  int          at [0:127];
  int          n;
  int          cyc;
  assign out_ready = !stall;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n <= 0;
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
      if (output_valid) begin
        got[n % 128] <= sample_out;
        at[n % 128] <= cyc;
        n <= n + 1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/mfd_top_test.sv]
`timescale 1ns/10ps
`default_nettype none
`include "mfd_defines.vh"
module mfd_top_test;
  logic        pclk, presetn, psel, penable, pwrite, ce, stall, err;
  logic        new_sample_strobe;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd, st;
  logic [11:0] sample_in;
  wire  [31:0] prdata;
  wire  [17:0] sample_out;
  wire         pready, pslverr, ready_for_data, output_valid, out_ready;
  int          mismatches, cmp_count, w, j, k, d, base;
  mfd_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_in(sample_in), .new_sample_strobe(new_sample_strobe),
    .ce(ce), .ready_for_data(ready_for_data), .sample_out(sample_out),
    .output_valid(output_valid), .out_ready(out_ready));
  mfd_sink sink_u (.pclk(pclk), .presetn(presetn), .sample_out(sample_out),
    .output_valid(output_valid), .out_ready(out_ready), .stall(stall));
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  task conclude;
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    cmp_count++;
    if (seen !== ex) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    if (i == 20) begin
      mismatches++;
      conclude;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task push(input logic [11:0] v, input int lim);
    logic r;
    new_sample_strobe <= 1'b1;
    sample_in <= v;
    for (w = 0; w < lim; w++) begin
      // Ready settled before the edge that takes the sample
      @(negedge pclk);
      r = ready_for_data;
      @(posedge pclk);
      if (r === 1'b1) break;
    end
  endtask
  task wait_words(input int t);
    int i;
    for (i = 0; i < 400 && sink_u.n < t; i++) @(posedge pclk);
    if (sink_u.n < t) begin
      mismatches++;
      conclude;
    end
  endtask
  initial begin
    {presetn, psel, penable, pwrite, ce, stall, new_sample_strobe} = 0;
    paddr = 0;
    pwdata = 0;
    sample_in = 0;
    mismatches = 0;
    cmp_count = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (j = 0; j < 3; j++) begin
      apb(1'b0, j * 4, 32'h0);
      chk("reset", rd, j == 2 ? 32'h4 : 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    for (j = 0; j < 20; j++) begin
      push(j, 100);
      chk("wait", (w != 0) + 2 * (w == 100), j >= 8 && j % 4 == 0);
    end
    // Sink stalls: buffer fills until input refused
    stall <= 1'b1;
    for (j = 20; j < 40 && w < 60; j++) push(j, 60);
    chk("full", w, 60);
    stall <= 1'b0;
    j = j - 1;
    do begin
      push(j, 100);
      j++;
    end while (j % 4 != 0);
    new_sample_strobe <= 1'b0;
    wait_words(j / 4);
    for (k = 0; k < j / 4; k++)
      chk("dec", sink_u.got[k], 16 * k + 6);
    base = j / 4;
    for (j = 0; j < 11; j++) begin
      apb(1'b1, `MFD_ADDR_CTRL, j == 10 ? 32'h5 : 32'h1);
      apb(1'b1, `MFD_ADDR_ROUND, j == 10 ? 32'h1 : j);
      push(12'h0b7, 100);
      new_sample_strobe <= 1'b0;
      wait_words(base + 4);
      for (k = 0; k < 4; k++) begin
        d = sink_u.got[base + k] - ((183 * (k + 1)) >> (j % 10 ? 4 : 0));
        chk("round", d < 0 || d > (j > 1 && j < 10), 0);
      end
      base += 4;
    end
    apb(1'b1, `MFD_ADDR_CTRL, 32'h1);
    apb(1'b1, `MFD_ADDR_ROUND, 32'h0);
    for (j = 0; j < 4; j++) push(j + 1, 100);
    new_sample_strobe <= 1'b0;
    wait_words(base + 16);
    chk("span", sink_u.at[base + 15] - sink_u.at[base], 15);
    base += 16;
    apb(1'b1, `MFD_ADDR_CYCLES, 32'h8);
    for (j = 0; j < 2; j++) push(j + 1, 100);
    new_sample_strobe <= 1'b0;
    wait_words(base + 8);
    chk("blk", sink_u.at[base + 4] - sink_u.at[base], 8);
    chk("blk_last", sink_u.got[base + 7], 8);
    base += 8;
    apb(1'b0, `MFD_ADDR_OUTCNT, 32'h0);
    chk("outcnt", rd, base);
    apb(1'b1, `MFD_ADDR_CTRL, 32'h2);
    apb(1'b0, `MFD_ADDR_STATUS, 32'h0);
    st = rd;
    new_sample_strobe <= 1'b1;
    sample_in <= 12'h004;
    repeat (10) @(posedge pclk);
    apb(1'b0, `MFD_ADDR_STATUS, 32'h0);
    chk("ce_idle", rd, st);
    ce <= 1'b1;
    wait_words(base + 1);
    chk("ce_run", sink_u.got[base], 16);
    conclude;
  end
endmodule
`default_nettype wire
